// ### verilog/sasc_top.sv
/*
  Converter scan controller: two low-power single-shot controllers,
  two pattern-table scan controllers, amplifier sequencing and the
  audio-port result path. Assumes two converters that take a start
  pulse with an entry and answer with a done pulse and right-aligned
  data, and a register master that never waits.
*/
// Function
// - Low-power trigger starts one conversion, result readable
// - Low-power side: no scanning, no stream transfer
// - Amplifier reachable only from first low-power controller
// - Fast controllers start scans, never single conversions
// - Sixteen-entry table read in order; repeats only on audio start
// - Entry: channel, resolution, attenuation, eight bits
// - Resolution codes give 9, 10, 11, 12 bits
// - Single mode uses one configured converter
// - Double mode converts on both converters together
// - Alternate mode takes converters in turn
// - Single word: channel 15:12, data 11:0
// - Dual word: converter bit, channel, data 10:0
// - Results truncated to 12 or 11 bits
// - Scan starts by software or audio port
// - Scan completion raises an event
// - Word-select edge triggers; data ready flagged
// - Config bit connects first fast controller results to audio port
// - Amplifier enable powers and connects amplifier first
// - Feedback reset pulse, then reference short
// - First converter starts after amplifier settles
// - Amplifier driven by first low-power controller
`timescale 1ns/1ps
module sasc_top
  import sasc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Coprocessor conversion triggers
  input wire logic [1:0] conversion_trigger,
  // Converters
  output sasc_conv_req_t [1:0] conv_req,
  input sasc_conv_rsp_t [1:0] conv_rsp,
  // Amplifier
  output sasc_amp_t amp,
  // Audio serial port
  input wire logic audio_ws,
  output logic [15:0] audio_word,
  output logic audio_data_ready,
  // Scan completion events
  output logic [1:0] scan_done
);
  typedef enum logic [1:0] {LP_IDLE, LP_AMP, LP_CONV} sasc_lp_st_t;
  typedef enum logic [1:0] {F_IDLE, F_WAIT, F_CONV, F_EMIT}
    sasc_fs_st_t;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  // Asynchronous assert, two-flop release
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] cfg_q;
  sasc_fcfg_t [1:0] fcfg_q;
  sasc_entry_t [1:0] lp_ch_q;
  sasc_entry_t tbl_q [2][16];
  logic [1:0][11:0] lp_res_q;
  logic [1:0] lp_valid_q;
  sasc_lp_st_t lp_q [2];
  logic [1:0] done_q;
  logic [1:0][15:0] word_q;
  logic [1:0] word_v_q;
  sasc_fs_st_t fs_q [2];
  logic [1:0][3:0] idx_q;
  logic [1:0] alt_q;
  logic [1:0] audio_q;
  logic [1:0][1:0] mode_q;
  logic [1:0] sel_q;
  logic [1:0][3:0] last_q;
  logic [1:0][1:0] need_q;
  logic [1:0][1:0] got_q;
  logic [1:0][1:0][11:0] res_q;
  logic ws_prev_q;
  logic ws_edge;
  logic [1:0] lp_trig;
  logic [1:0] fast_start;
  logic [31:0] rd_val;
  logic amp_start;
  logic amp_release;
  logic amp_ready;
  sasc_scan_req_t [1:0][2:0] arb_req;
  logic [1:0][2:0] arb_done;

  // Page hit for pattern-table addresses
  function automatic logic tbl_hit(input logic [7:0] a,
    input logic k);
    tbl_hit = (a[7:6] == (k ? TBL_PAGE1 : TBL_PAGE0));
  endfunction

  // Converters wanted by a step
  function automatic logic [1:0] step_need(input logic [1:0] m,
    input logic sel, input logic alt);
    case (m)
      MODE_DOUBLE: step_need = 2'b11;
      MODE_ALT: step_need = alt ? 2'b10 : 2'b01;
      default: step_need = sel ? 2'b10 : 2'b01;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Command bits are pulses, never stored; there is deliberately no
  // single-conversion command for the fast side
  assign lp_trig = conversion_trigger
    | ({2{reg_wr && reg_addr == OFS_CMD}}
       & reg_wdata[CMD_LP_TRIG +: 2]);
  assign fast_start = {2{reg_wr && reg_addr == OFS_CMD}}
    & reg_wdata[CMD_FAST_START +: 2];

  // Configuration registers
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      cfg_q <= CFG_RST;
      fcfg_q <= {2{FCFG_RST}};
      lp_ch_q <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == OFS_CFG)
        cfg_q <= reg_wdata[7:0];
      if (reg_addr == OFS_FCFG0)
        fcfg_q[0] <= sasc_fcfg_t'(reg_wdata[7:0]);
      if (reg_addr == OFS_FCFG1)
        fcfg_q[1] <= sasc_fcfg_t'(reg_wdata[7:0]);
      if (reg_addr == OFS_LPCH)
        lp_ch_q <= reg_wdata[15:0];
    end

  // Pattern tables, one aligned word per entry
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      for (int k = 0; k < 2; k++)
        for (int i = 0; i < 16; i++)
          tbl_q[k][i] <= ENTRY_RST;
    end
    else if (reg_wr)
      for (int k = 0; k < 2; k++)
        if (tbl_hit(reg_addr, k[0]))
          tbl_q[k][reg_addr[5:2]] <= reg_wdata[7:0];

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_val = '0;
    case (reg_addr)
      OFS_CFG: rd_val[7:0] = cfg_q;
      OFS_FCFG0: rd_val[7:0] = fcfg_q[0];
      OFS_FCFG1: rd_val[7:0] = fcfg_q[1];
      OFS_LPCH: rd_val[15:0] = lp_ch_q;
      OFS_LPRES0, OFS_LPRES1:
      begin
        rd_val[11:0] = lp_res_q[reg_addr[3]];
        rd_val[RES_VALID] = lp_valid_q[reg_addr[3]];
        rd_val[RES_BUSY] = (lp_q[reg_addr[3]] != LP_IDLE);
      end
      OFS_STATUS:
      begin
        rd_val[ST_BUSY] = (fs_q[0] != F_IDLE);
        rd_val[ST_BUSY + 1] = (fs_q[1] != F_IDLE);
        rd_val[ST_DONE +: 2] = done_q;
      end
      OFS_WORD: rd_val = {word_q[1], word_q[0]};
      default:
        for (int k = 0; k < 2; k++)
          if (tbl_hit(reg_addr, k[0]))
            rd_val[7:0] = tbl_q[k][reg_addr[5:2]];
    endcase
  end

  // Data stand for one cycle only, zero otherwise
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_rd ? rd_val : '0;

  // ----------------------------------------------------------------
  // Low-power controllers
  // ----------------------------------------------------------------
  // Single shot only; a trigger while busy is dropped. Sequences
  // come from repeated coprocessor triggers, not from here.
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      lp_q[0] <= LP_IDLE;
      lp_q[1] <= LP_IDLE;
      lp_res_q <= '0;
      lp_valid_q <= '0;
    end
    else
      for (int k = 0; k < 2; k++)
        case (lp_q[k])
          LP_IDLE:
            if (lp_trig[k])
            begin
              lp_valid_q[k] <= 1'b0;
              // Amplifier path exists on the first controller only
              if (k == 0 && cfg_q[CFG_AMP_EN])
                lp_q[k] <= LP_AMP;
              else
                lp_q[k] <= LP_CONV;
            end
          LP_AMP:
            if (amp_ready)
              lp_q[k] <= LP_CONV;
          LP_CONV:
            if (arb_done[k][2])
            begin
              lp_res_q[k] <= conv_rsp[k].data;
              lp_valid_q[k] <= 1'b1;
              lp_q[k] <= LP_IDLE;
            end
          default:
            lp_q[k] <= LP_IDLE;
        endcase

  // Amplifier runs under the first controller
  assign amp_start = (lp_q[0] == LP_IDLE) && lp_trig[0]
    && cfg_q[CFG_AMP_EN];
  assign amp_release = (lp_q[0] == LP_CONV) && arb_done[0][2];

  sasc_amp_seq u_amp (
    .clk(ref_clk),
    .rst_n(rst_n),
    .start(amp_start),
    .release_amp(amp_release),
    .gnd_short(cfg_q[CFG_GND_SHORT]),
    .amp(amp),
    .ready(amp_ready)
  );

  // ----------------------------------------------------------------
  // Audio port trigger
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      ws_prev_q <= 1'b0;
    else
      ws_prev_q <= audio_ws;
  // Either edge of word select counts, only while routed
  assign ws_edge = cfg_q[CFG_ROUTE]
    && (audio_ws != ws_prev_q);

  // ----------------------------------------------------------------
  // Fast scan controllers
  // ----------------------------------------------------------------
  // Software start runs one pass; audio start steps per word-select
  // edge and wraps until its trigger bit is cleared
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      for (int k = 0; k < 2; k++)
        fs_q[k] <= F_IDLE;
      idx_q <= '0;
      alt_q <= '0;
      audio_q <= '0;
      mode_q <= '0;
      sel_q <= '0;
      last_q <= '0;
      need_q <= '0;
      got_q <= '0;
      res_q <= '0;
      word_q <= '0;
      word_v_q <= '0;
      scan_done <= '0;
    end
    else
      for (int k = 0; k < 2; k++)
      begin
        word_v_q[k] <= 1'b0;
        scan_done[k] <= 1'b0;
        case (fs_q[k])
          F_IDLE:
            if (fast_start[k]
                || (fcfg_q[k].audio_trig && ws_edge))
            begin
              mode_q[k] <= fcfg_q[k].mode;
              sel_q[k] <= fcfg_q[k].conv_sel;
              last_q[k] <= fcfg_q[k].last;
              audio_q[k] <= fcfg_q[k].audio_trig && !fast_start[k];
              idx_q[k] <= '0;
              alt_q[k] <= 1'b0;
              got_q[k] <= '0;
              need_q[k] <= step_need(fcfg_q[k].mode,
                fcfg_q[k].conv_sel, 1'b0);
              fs_q[k] <= F_CONV;
            end
          F_WAIT:
            if (!audio_q[k] || ws_edge)
            begin
              got_q[k] <= '0;
              need_q[k] <= step_need(mode_q[k], sel_q[k], alt_q[k]);
              fs_q[k] <= F_CONV;
            end
          F_CONV:
          begin
            for (int c = 0; c < 2; c++)
              if (arb_done[c][k])
              begin
                got_q[k][c] <= 1'b1;
                res_q[k][c] <= conv_rsp[c].data;
              end
            if (((got_q[k] | {arb_done[1][k], arb_done[0][k]})
                 & need_q[k]) == need_q[k])
              fs_q[k] <= F_EMIT;
          end
          F_EMIT:
          begin
            // One word a cycle, first converter first
            for (int c = 1; c >= 0; c--)
              if (need_q[k][c])
                word_q[k] <= pack_word(mode_q[k], c[0],
                  tbl_q[k][idx_q[k]], res_q[k][c]);
            word_v_q[k] <= 1'b1;
            need_q[k] <= need_q[k][0] ? {need_q[k][1], 1'b0} : 2'b00;
            if (!need_q[k][0] || need_q[k] == 2'b01)
            begin
              idx_q[k] <= idx_q[k] + 1'b1;
              alt_q[k] <= (mode_q[k] == MODE_ALT) && !alt_q[k];
              fs_q[k] <= F_WAIT;
              if (idx_q[k] == last_q[k])
              begin
                idx_q[k] <= '0;
                scan_done[k] <= 1'b1;
                if (!(audio_q[k] && fcfg_q[k].audio_trig))
                  fs_q[k] <= F_IDLE;
              end
            end
          end
          default:
            fs_q[k] <= F_IDLE;
        endcase
      end

  // Sticky completion flags; a new completion beats the clear
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      done_q <= '0;
    else
      done_q <= (done_q & ~({2{reg_wr && reg_addr == OFS_STATUS}}
                 & reg_wdata[ST_DONE +: 2])) | scan_done;

  // ----------------------------------------------------------------
  // Converter sharing
  // ----------------------------------------------------------------
  always_comb
    for (int c = 0; c < 2; c++)
    begin
      for (int k = 0; k < 2; k++)
      begin
        arb_req[c][k].valid = (fs_q[k] == F_CONV)
          && need_q[k][c] && !got_q[k][c];
        arb_req[c][k].entry = tbl_q[k][idx_q[k]];
      end
      arb_req[c][2].valid = (lp_q[c] == LP_CONV);
      arb_req[c][2].entry = lp_ch_q[c];
    end

  sasc_conv_arb u_arb0 (
    .clk(ref_clk),
    .rst_n(rst_n),
    .req(arb_req[0]),
    .done(arb_done[0]),
    .conv_req(conv_req[0]),
    .conv_rsp(conv_rsp[0])
  );

  sasc_conv_arb u_arb1 (
    .clk(ref_clk),
    .rst_n(rst_n),
    .req(arb_req[1]),
    .done(arb_done[1]),
    .conv_req(conv_req[1]),
    .conv_rsp(conv_rsp[1])
  );

  // ----------------------------------------------------------------
  // Audio port result path
  // ----------------------------------------------------------------
  // Only the first fast controller has the stream path
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      audio_word <= '0;
      audio_data_ready <= 1'b0;
    end
    else
    begin
      audio_data_ready <= word_v_q[0] && cfg_q[CFG_ROUTE];
      if (word_v_q[0] && cfg_q[CFG_ROUTE])
        audio_word <= word_q[0];
    end
endmodule

// ### shared/sasc_pkg.sv
/*
  Constants, types and helpers shared by the converter scan controller.
  Assumes a 20 MHz ref_clk and a byte-addressed register port.
*/
package sasc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int AMP_PWR_NS = 1000;
  localparam int AMP_RST_NS = 500;
  localparam int AMP_SETTLE_NS = 2000;
  // Least times, rounded up to whole cycles
  localparam int AMP_PWR_CYC = (AMP_PWR_NS * CLK_MHZ + 999) / 1000;
  localparam int AMP_RST_CYC = (AMP_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int AMP_SET_CYC = (AMP_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int AMP_CNT_W = 8;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_FCFG0 = 8'h08;
  localparam logic [7:0] OFS_FCFG1 = 8'h0C;
  localparam logic [7:0] OFS_LPCH = 8'h10;
  localparam logic [7:0] OFS_LPRES0 = 8'h14;
  localparam logic [7:0] OFS_LPRES1 = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_WORD = 8'h20;
  localparam logic [1:0] TBL_PAGE0 = 2'h1;
  localparam logic [1:0] TBL_PAGE1 = 2'h2;
  localparam int CMD_LP_TRIG = 0;
  localparam int CMD_FAST_START = 2;
  localparam int CFG_ROUTE = 0;
  localparam int CFG_AMP_EN = 1;
  localparam int CFG_GND_SHORT = 2;
  localparam int RES_VALID = 16;
  localparam int RES_BUSY = 17;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 8;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] FCFG_RST = 8'h00;
  localparam logic [7:0] ENTRY_RST = 8'h00;

  // Resolution codes: 9, 10, 11, 12 bits
  localparam logic [1:0] RES_12 = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_SINGLE, MODE_DOUBLE, MODE_ALT}
    sasc_mode_t;
  typedef struct packed {
    logic [3:0] channel_select;
    logic [1:0] width;
    logic [1:0] atten;
  } sasc_entry_t;
  typedef struct packed {
    logic [3:0] last;
    logic audio_trig;
    logic conv_sel;
    logic [1:0] mode;
  } sasc_fcfg_t;
  typedef struct packed {
    logic valid;
    sasc_entry_t entry;
  } sasc_scan_req_t;
  typedef struct packed {
    logic start;
    sasc_entry_t entry;
  } sasc_conv_req_t;
  typedef struct packed {
    logic done;
    logic [11:0] data;
  } sasc_conv_rsp_t;
  typedef struct packed {
    logic power;
    logic connect;
    logic fb_reset;
    logic short_ref;
    logic short_gnd;
  } sasc_amp_t;

  // Packs one result into the 16-bit stream word
  function automatic logic [15:0] pack_word(input logic [1:0] mode,
    input logic sel, input sasc_entry_t e, input logic [11:0] d);
    if (mode == MODE_DOUBLE || mode == MODE_ALT)
      pack_word = {sel, e.channel_select,
                   (e.width == RES_12) ? d[11:1] : d[10:0]};
    else
      pack_word = {e.channel_select, d};
  endfunction
endpackage

// ### verilog/sasc_amp_seq.sv
/*
  Low-noise amplifier sequencer: power up, feedback reset pulse,
  reference short, settle. Assumes start and release are one-cycle
  pulses from the first low-power controller.
*/
`timescale 1ns/1ps
module sasc_amp_seq
  import sasc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic release_amp,
  input wire logic gnd_short,
  // Amplifier pins and status
  output sasc_amp_t amp,
  output logic ready
);
  typedef enum logic [2:0] {A_OFF, A_PWR, A_RST, A_INT, A_RDY}
    sasc_amp_st_t;
  sasc_amp_st_t st_q;
  logic [AMP_CNT_W-1:0] cnt_q;

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      st_q <= A_OFF;
      cnt_q <= '0;
    end
    else if (release_amp)
    begin
      st_q <= A_OFF;
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      case (st_q)
        A_OFF:
          if (start)
          begin
            st_q <= A_PWR;
            cnt_q <= '0;
          end
        A_PWR:
          if (cnt_q == AMP_CNT_W'(AMP_PWR_CYC - 1))
          begin
            st_q <= A_RST;
            cnt_q <= '0;
          end
        A_RST:
          if (cnt_q == AMP_CNT_W'(AMP_RST_CYC - 1))
          begin
            st_q <= A_INT;
            cnt_q <= '0;
          end
        A_INT:
          if (cnt_q == AMP_CNT_W'(AMP_SET_CYC - 1))
            st_q <= A_RDY;
        A_RDY:
          cnt_q <= '0;
        default:
          st_q <= A_OFF;
      endcase
    end

  // Pin levels follow the state; ground short only if software asks
  always_comb
  begin
    amp.power = (st_q != A_OFF);
    amp.connect = (st_q != A_OFF);
    amp.fb_reset = (st_q == A_RST);
    amp.short_ref = (st_q == A_INT || st_q == A_RDY) && !gnd_short;
    amp.short_gnd = (st_q == A_INT || st_q == A_RDY) && gnd_short;
  end
  assign ready = (st_q == A_RDY);
endmodule

// ### verilog/sasc_conv_arb.sv
/*
  Shares one converter among three requesters: fast one, fast two,
  low-power. Assumes a requester holds valid until it sees done.
*/
`timescale 1ns/1ps
module sasc_conv_arb
  import sasc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requesters
  input sasc_scan_req_t [2:0] req,
  output logic [2:0] done,
  // Converter
  output sasc_conv_req_t conv_req,
  input sasc_conv_rsp_t conv_rsp
);
  typedef enum logic [1:0] {OWN_NONE, OWN_0, OWN_1, OWN_2}
    sasc_own_t;
  sasc_own_t own_q;

  // ----------------------------------------------------------------
  // Grant, fixed priority; held until the result comes back
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      own_q <= OWN_NONE;
      conv_req <= '0;
    end
    else
    begin
      conv_req.start <= 1'b0;
      case (own_q)
        OWN_NONE:
          for (int i = 2; i >= 0; i--)
            if (req[i].valid)
            begin
              own_q <= sasc_own_t'(2'(i + 1));
              conv_req.start <= 1'b1;
              conv_req.entry <= req[i].entry;
            end
        default:
          if (conv_rsp.done)
            own_q <= OWN_NONE;
      endcase
    end

  // Completion goes only to the owner
  always_comb
    for (int i = 0; i < 3; i++)
      done[i] = conv_rsp.done && (own_q == sasc_own_t'(2'(i + 1)));
endmodule

// ### dv/sasc_conv_model.sv
/*
  Behavioural converter answering start pulses.
  Assumes one start at a time per converter.
*/
`timescale 1ns/1ps
module sasc_conv_model
  import sasc_pkg::*;
#(parameter int DLY = 1)
(
  // Clock
  input wire logic clk,
  // Request and answer
  input sasc_conv_req_t req,
  output sasc_conv_rsp_t rsp
);
  int cnt_q = 0;
  logic [11:0] val_q = 12'h000;
  initial rsp = '0;
  // Data scrambles outside done so stale values never match
  always @(posedge clk)
  begin
    rsp.done <= 1'b0;
    rsp.data <= ~rsp.data;
    if (cnt_q == 1)
    begin
      rsp.done <= 1'b1;
      rsp.data <= val_q;
    end
    if (cnt_q > 0)
      cnt_q <= cnt_q - 1;
    if (req.start === 1'b1)
    begin
      cnt_q <= DLY;
      val_q <= {req.entry, 4'h9};
    end
  end
endmodule

// ### dv/sasc_top_sva.sv
/*
  Port checks for the scan controller.
  Assumes it is bound to sasc_top.
*/
`timescale 1ns/1ps
module sasc_top_chk
  import sasc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Watched ports
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input sasc_conv_req_t [1:0] conv_req,
  input sasc_amp_t amp,
  input wire logic [1:0] scan_done
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // Amplifier steps
  sequence s_pwr;
    (amp.power && !amp.fb_reset && !amp.short_ref) [*8];
  endsequence
  sequence s_hold;
    (!conv_req[0].start) [*8];
  endsequence
  property p_rd;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("stray rdata");
  property p_start;
    conv_req[0].start |=> !conv_req[0].start;
  endproperty
  a_start: assert property (p_start) else $error("long start");
  property p_done;
    scan_done[0] |=> !scan_done[0];
  endproperty
  a_done: assert property (p_done) else $error("long done");
  property p_fb;
    amp.fb_reset |-> amp.power && amp.connect;
  endproperty
  a_fb: assert property (p_fb) else $error("fb unpowered");
  property p_excl;
    !(amp.short_ref && amp.short_gnd);
  endproperty
  a_excl: assert property (p_excl) else $error("two shorts");
  property p_pwr;
    $rose(amp.power) |-> s_pwr;
  endproperty
  a_pwr: assert property (p_pwr) else $error("early step");
  property p_ord;
    $rose(amp.short_ref || amp.short_gnd) |-> $past(amp.fb_reset);
  endproperty
  a_ord: assert property (p_ord) else $error("short early");
  property p_set;
    $rose(amp.short_ref || amp.short_gnd) |-> s_hold;
  endproperty
  a_set: assert property (p_set) else $error("unsettled");
endmodule

bind sasc_top sasc_top_chk sasc_top_chk_inst (.ref_clk, .nrst, .reg_rd,
  .reg_rdata, .conv_req, .amp, .scan_done);

// ### dv/tb_top.sv
/*
  Self-checking bench for the scan controller.
  Assumes two behavioural converters.
*/
`timescale 1ns/1ps
module tb_top;
  import sasc_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] conversion_trigger = 2'h0;
  sasc_conv_req_t [1:0] conv_req;
  sasc_conv_rsp_t [1:0] conv_rsp;
  sasc_amp_t amp;
  logic audio_ws = 1'b0;
  logic [15:0] audio_word;
  logic audio_data_ready;
  logic [1:0] scan_done;
  int err_count = 0;
  int checked = 0;
  int st [2];
  logic [15:0] words [$];
  sasc_entry_t tbl [16];
  initial forever #25 ref_clk = ~ref_clk;
  sasc_top sasc_top_inst (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .conversion_trigger, .conv_req, .conv_rsp, .amp,
    .audio_ws, .audio_word, .audio_data_ready, .scan_done);
  sasc_conv_model #(.DLY(3)) conv0_model (.clk(ref_clk),
    .req(conv_req[0]), .rsp(conv_rsp[0]));
  sasc_conv_model conv1_model (.clk(ref_clk),
    .req(conv_req[1]), .rsp(conv_rsp[1]));
  // Collect stream words and converter starts
  always @(posedge ref_clk)
  begin
    if (audio_data_ready === 1'b1)
      words.push_back(audio_word);
    for (int i = 0; i < 2; i++)
      st[i] += (conv_req[i].start === 1'b1);
  end
  task automatic end_sim();
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // Bounded waits; running out counts as a mismatch
  task automatic wt(input logic [7:0] a, output logic [31:0] q);
    for (int i = 0; i < 400; i++)
    begin
      if (a == 8'hFF)
        @(posedge ref_clk);
      else
        rd(a, q);
      if (a == 8'hFF ? scan_done[0] === 1'b1 : q[RES_VALID] === 1'b1)
        return;
    end
    chk(32'h1, 32'h0);
    end_sim();
  endtask
  function automatic logic [15:0] xw(input logic [1:0] m, input logic s,
    input sasc_entry_t e);
    logic [11:0] d;
    d = {e, 4'h9};
    xw = (m == 2'h0) ? {e.channel_select, d} : {s, e.channel_select,
      (e.width == 2'h3) ? d[11:1] : d[10:0]};
  endfunction
  task automatic scan(input logic [1:0] m, input logic s,
    input logic [3:0] l, input logic rt);
    int n;
    int a;
    logic [31:0] q;
    n = (m == 2'h1) ? 2 * (l + 1) : l + 1;
    a = (m == 2'h0) ? (s ? 0 : n) : (m == 2'h1) ? l + 1 : (l + 2) / 2;
    wr(OFS_CFG, {31'h0, rt});
    wr(OFS_FCFG0, {24'h0, l, 1'b0, s, m});
    words.delete();
    st = '{0, 0};
    wr(OFS_CMD, 32'h4);
    wt(8'hFF, q);
    repeat (3) @(posedge ref_clk);
    chk(st[0], a);
    chk(st[1], n - a);
    chk(words.size(), rt ? n : 0);
    for (int k = 0; k < words.size(); k++)
      chk(words[k], xw(m, (m == 2'h0) ? 1'b0 : k[0],
        tbl[(m == 2'h1) ? k / 2 : k]));
  endtask
  // Main sequence
  initial
  begin
    logic [31:0] q;
    logic [31:0] lp;
    logic [7:0] ra [4] = '{OFS_CMD, OFS_CFG, OFS_FCFG0, 8'h30};
    q = $urandom(13);
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    foreach (ra[i])
    begin
      rd(ra[i], q);
      chk(q, 32'h0);
    end
    for (int i = 0; i < 16; i++)
    begin
      tbl[i] = 8'($urandom);
      wr(8'h40 + 8'(4 * i), {24'h0, tbl[i]});
      rd(8'h40 + 8'(4 * i), q);
      chk(q, {24'h0, tbl[i]});
    end
    lp = $urandom;
    wr(OFS_CFG, 32'h1);
    wr(OFS_LPCH, lp);
    conversion_trigger <= 2'h1;
    @(posedge ref_clk);
    conversion_trigger <= 2'h0;
    wt(OFS_LPRES0, q);
    chk(q[11:0], {lp[7:0], 4'h9});
    wr(OFS_CMD, 32'h2);
    wt(OFS_LPRES1, q);
    chk(q[11:0], {lp[15:8], 4'h9});
    chk(words.size(), 0);
    for (int g = 0; g < 2; g++)
    begin
      wr(OFS_CFG, {29'h0, g[0], 2'b11});
      wr(OFS_CMD, 32'h1);
      wt(OFS_LPRES0, q);
      chk(q[11:0], {lp[7:0], 4'h9});
    end
    wr(OFS_CMD, 32'h2);
    wt(OFS_LPRES1, q);
    chk(amp.power, 1'b0);
    scan(2'h0, 1'b0, 4'hF, 1'b0);
    for (int m = 0; m < 3; m++)
      scan(m[1:0], 1'($urandom), 4'($urandom), 1'b1);
    // Second fast controller: one-entry pass, word and sticky status
    wr(8'h80, {24'h0, tbl[3]});
    wr(OFS_FCFG1, 32'h0);
    wr(OFS_CMD, 32'h8);
    repeat (20) @(posedge ref_clk);
    rd(OFS_WORD, q);
    chk(q[31:16], xw(2'h0, 1'b0, tbl[3]));
    rd(OFS_STATUS, q);
    chk(q[9:0], 10'h300);
    wr(OFS_STATUS, 32'h300);
    rd(OFS_STATUS, q);
    chk(q[9:0], 10'h0);
    wr(OFS_CFG, 32'h1);
    wr(OFS_FCFG0, 32'h18);
    words.delete();
    for (int k = 0; k < 2; k++)
    begin
      repeat (20) @(posedge ref_clk);
      audio_ws <= ~audio_ws;
      repeat (20) @(posedge ref_clk);
      chk(words[k], xw(2'h0, 1'b0, tbl[k]));
    end
    end_sim();
  end
endmodule
